/* File: common/gpd_regs.svh */
// register offsets, field masks, reset values and base address of the port d block
`ifndef GPD_REGS_SVH
`define GPD_REGS_SVH

// ==========================================================================
// base address of the register window
// ==========================================================================
`define GPD_BASE_ADDR      32'h400c_0300
`define GPD_BASE_MASK      32'hffff_ff00

// ==========================================================================
// register byte offsets within the window
// ==========================================================================
`define GPD_OFS_LEVEL      8'h00
`define GPD_OFS_OUT_EN     8'h04
`define GPD_OFS_FN_ADDR    8'h08
`define GPD_OFS_FN_SERIAL  8'h0c
`define GPD_OFS_FN_FLOW    8'h10
`define GPD_OFS_OPEN_DRAIN 8'h28
`define GPD_OFS_PULLUP     8'h2c
`define GPD_OFS_IN_EN      8'h38
`define GPD_OFS_CONFLICT   8'h3c

// ==========================================================================
// writable bit masks and reset values
// ==========================================================================
`define GPD_MASK_FULL      8'hff
`define GPD_MASK_SERIAL    8'hf7
`define GPD_MASK_FLOW      8'h44
`define GPD_RST_BYTE       8'h00

// ==========================================================================
// serial-function bit positions inside the serial select register
// ==========================================================================
`define GPD_BIT_TX10       0
`define GPD_BIT_RX10       1
`define GPD_BIT_CLK10      2
`define GPD_BIT_TX11       4
`define GPD_BIT_RX11       5
`define GPD_BIT_CLK11      6
`define GPD_BIT_IRQB       7

`endif

/* File: common/gpd_pkg.sv */
// types shared by the port d pin multiplexer
package gpd_pkg;

    // one byte, one bit per pin
    typedef logic [7:0] gpd_pins_t;

    // which source owns a pin
    typedef enum logic [1:0] {
        GPD_FN_PORT,
        GPD_FN_ADDR,
        GPD_FN_SERIAL,
        GPD_FN_FLOW
    } gpd_func_t;

endpackage

/* File: verilog/gpd_sync2.sv */
// two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps

module gpd_sync2 #(
    parameter int WIDTH = 8                  // number of bits synchronised
) (
    input  wire logic             clk_in,    // system clock
    input  wire logic             nrst_in,   // synchronised reset, active low
    input  wire logic [WIDTH-1:0] async_in,  // levels from outside the domain
    output logic      [WIDTH-1:0] sync_out   // stable copy
);

    logic [WIDTH-1:0] meta_q;                // first stage, read only by second

    // ======================================================================
    // two flops; nothing else looks at the first stage
    // ======================================================================
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // gpd_sync2

/* File: verilog/gpd_pin_cell.sv */
// one pad cell: driver, open-drain shaping and gated input sampling
`timescale 1ns/1ps

module gpd_pin_cell (
    input  wire logic clk_in,        // system clock
    input  wire logic nrst_in,       // synchronised reset, active low
    input  wire logic drive_req_in,  // driver wanted this cycle
    input  wire logic drive_val_in,  // level to put on the pin
    input  wire logic open_drain_in, // 1: only pull low
    input  wire logic in_en_in,      // input buffer enable
    input  wire logic pin_in,        // pad level, asynchronous
    output logic      pin_out,       // registered pad data
    output logic      pin_oe_out,    // registered pad enable, high drives
    output logic      level_out      // synchronised level, zero when buffer off
);

    logic pin_sync;                  // pad level after two flops

    // ======================================================================
    // input path
    // ======================================================================
    gpd_sync2 #(
        .WIDTH (1)
    ) u_sync (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // buffer off reads low so a floating pad cannot toggle anything
    assign level_out = pin_sync & in_en_in;

    // ======================================================================
    // output path, registered so the pad never sees decode glitches
    // ======================================================================
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_out    <= 1'b0;
            pin_oe_out <= 1'b0;
        end else if (open_drain_in) begin
            // open drain: data fixed low, enable carries the inverted level
            pin_out    <= 1'b0;
            pin_oe_out <= drive_req_in & ~drive_val_in;
        end else begin
            // push-pull
            pin_out    <= drive_val_in;
            pin_oe_out <= drive_req_in;
        end
    end

endmodule // gpd_pin_cell

/* File: verilog/gpd_port.sv */
// port d: eight-pin gpio with apb registers and alternate-function multiplexer
//
// Operation
// [RQ1] eight pins, direction per bit
// [RQ2] reset: plain port, buffers and pull-ups off
// [RQ3] all selects zero gives port; one routes function
// [RQ4] software never sets two selects per pin
// [RQ5] address use needs output enable and select
// [RQ6] registers at fixed base and offsets
// [RQ7] data register bits 7-0, upper zero
// [RQ8] output enable per bit, upper zero
// [RQ9] address select maps pins to lines 9..16
// [RQ10] serial select: irq, channel 11, channel 10
// [RQ11] flow select: clear-to-send bits 6 and 2
// [RQ12] open-drain select per bit
// [RQ13] pull-up enable per bit, resets zero
// [RQ14] input enable per bit, resets zero
// [RQ15] port mode drives data bit or floats
`timescale 1ns/1ps
`include "gpd_regs.svh"

module gpd_port
    import gpd_pkg::*;
#(
    parameter int PINS = 8                      // pin count of the port
) (
    // clock and reset
    input  wire logic            clk_in,              // 200 MHz system clock
    input  wire logic            nrst_in,             // async reset, active low
    // apb slave
    input  wire logic            psel_in,             // slave select
    input  wire logic            penable_in,          // access phase
    input  wire logic            pwrite_in,           // 1 write, 0 read
    input  wire logic [31:0]     paddr_in,            // byte address
    input  wire logic [31:0]     pwdata_in,           // write data
    output logic      [31:0]     prdata_out,          // read data
    output logic                 pready_out,          // always ready
    output logic                 pslverr_out,         // unmapped access
    // pads
    input  wire logic [PINS-1:0] pin_in,              // pad levels
    output logic      [PINS-1:0] pin_out,             // pad data
    output logic      [PINS-1:0] pin_oe_out,          // pad driver enable
    output logic      [PINS-1:0] pin_pullup_out,      // pull-up enable
    output logic      [PINS-1:0] pin_ie_out,          // input buffer enable
    // external bus controller
    input  wire logic [PINS-1:0] ext_addr_in,         // address lines 9..16
    // serial channel 10
    input  wire logic            serial_tx_ch10_in,   // transmit data
    input  wire logic            serial_clock_ch10_in,  // clock when master
    input  wire logic            serial_clock_ch10_oe_in, // 1: channel drives clock
    output logic                 serial_rx_ch10_out,  // receive data
    output logic                 serial_clock_ch10_out, // clock seen on pin
    output logic                 clear_to_send_ch10_out, // cts seen on pin
    // serial channel 11
    input  wire logic            serial_tx_ch11_in,   // transmit data
    input  wire logic            serial_clock_ch11_in,  // clock when master
    input  wire logic            serial_clock_ch11_oe_in, // 1: channel drives clock
    output logic                 serial_rx_ch11_out,  // receive data
    output logic                 serial_clock_ch11_out, // clock seen on pin
    output logic                 clear_to_send_ch11_out, // cts seen on pin
    // interrupt controller
    output logic                 ext_irq_line_b_out   // external interrupt level
);

    // ======================================================================
    // reset release
    // ======================================================================
    logic rst_meta_q;                           // first reset stage
    logic rst_n_q;                              // reset used by all logic

    // assert at once, release two edges later
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ======================================================================
    // registers
    // ======================================================================
    gpd_pins_t level_q;                         // pin_level_reg
    gpd_pins_t out_en_q;                        // output_enable_reg
    gpd_pins_t fn_addr_q;                       // address_function_select
    gpd_pins_t fn_serial_q;                     // serial_function_select
    gpd_pins_t fn_flow_q;                       // flow_function_select
    gpd_pins_t open_drain_q;                    // open_drain_select
    gpd_pins_t pullup_q;                        // pullup_enable_reg
    gpd_pins_t in_en_q;                         // input_enable_reg

    // ======================================================================
    // apb decode
    // ======================================================================
    logic [7:0]  reg_ofs;                       // offset inside window
    logic        in_window;                     // address hits this port
    logic        ofs_known;                     // offset names a register
    logic        setup_ph;                      // setup cycle
    logic        wr_fire;                       // write takes effect
    gpd_pins_t   wr_byte;                       // low write byte

    assign reg_ofs   = paddr_in[7:0];
    // base match plus word alignment; see [RQ6]
    assign in_window = ((paddr_in & `GPD_BASE_MASK) == `GPD_BASE_ADDR)
                     && (paddr_in[1:0] == 2'b00);
    assign setup_ph  = psel_in & ~penable_in;
    assign wr_byte   = pwdata_in[7:0];

    // offset table; anything else is an error
    always_comb begin
        unique case (reg_ofs)
            `GPD_OFS_LEVEL,
            `GPD_OFS_OUT_EN,
            `GPD_OFS_FN_ADDR,
            `GPD_OFS_FN_SERIAL,
            `GPD_OFS_FN_FLOW,
            `GPD_OFS_OPEN_DRAIN,
            `GPD_OFS_PULLUP,
            `GPD_OFS_IN_EN,
            `GPD_OFS_CONFLICT:   ofs_known = in_window;
            default:             ofs_known = 1'b0;
        endcase
    end

    // zero wait states: every access completes in its first access cycle
    assign pready_out  = 1'b1;
    // error only in the access phase, where the master samples it
    assign pslverr_out = psel_in & penable_in & ~ofs_known;
    // a refused write changes nothing
    assign wr_fire     = psel_in & penable_in & pwrite_in & ofs_known;

    // ======================================================================
    // register writes, one process per concern
    // ======================================================================

    // data and direction; see [RQ1]
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            level_q  <= `GPD_RST_BYTE;          // see [RQ7]
            out_en_q <= `GPD_RST_BYTE;          // outputs off; see [RQ2]
        end else if (wr_fire) begin
            if (reg_ofs == `GPD_OFS_LEVEL) begin
                level_q <= wr_byte;             // see [RQ7]
            end
            if (reg_ofs == `GPD_OFS_OUT_EN) begin
                out_en_q <= wr_byte;            // see [RQ8]
            end
        end
    end

    // function selects; reserved positions never store a one
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fn_addr_q   <= `GPD_RST_BYTE;       // plain port; see [RQ2]
            fn_serial_q <= `GPD_RST_BYTE;
            fn_flow_q   <= `GPD_RST_BYTE;
        end else if (wr_fire) begin
            if (reg_ofs == `GPD_OFS_FN_ADDR) begin
                fn_addr_q <= wr_byte & `GPD_MASK_FULL;     // see [RQ9]
            end
            if (reg_ofs == `GPD_OFS_FN_SERIAL) begin
                fn_serial_q <= wr_byte & `GPD_MASK_SERIAL; // see [RQ10]
            end
            if (reg_ofs == `GPD_OFS_FN_FLOW) begin
                fn_flow_q <= wr_byte & `GPD_MASK_FLOW;     // see [RQ11]
            end
        end
    end

    // pad controls
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            open_drain_q <= `GPD_RST_BYTE;      // cmos after reset
            pullup_q     <= `GPD_RST_BYTE;      // see [RQ13]
            in_en_q      <= `GPD_RST_BYTE;      // see [RQ14]
        end else if (wr_fire) begin
            if (reg_ofs == `GPD_OFS_OPEN_DRAIN) begin
                open_drain_q <= wr_byte;        // see [RQ12]
            end
            if (reg_ofs == `GPD_OFS_PULLUP) begin
                pullup_q <= wr_byte;            // see [RQ13]
            end
            if (reg_ofs == `GPD_OFS_IN_EN) begin
                in_en_q <= wr_byte;             // see [RQ14]
            end
        end
    end

    // pad static controls come straight from their registers
    assign pin_pullup_out = pullup_q;           // see [RQ13]
    assign pin_ie_out     = in_en_q;            // see [RQ14]

    // ======================================================================
    // alternate-function sources
    // ======================================================================
    gpd_pins_t ser_val;                         // serial output level per pin
    gpd_pins_t ser_drv;                         // serial wants to drive pin
    gpd_pins_t conflict;                        // more than one select set
    gpd_pins_t pin_level;                       // synchronised, gated levels

    // outputs of the serial channels laid onto their pin positions
    always_comb begin
        ser_val = '0;
        ser_drv = '0;
        ser_val[`GPD_BIT_TX10]  = serial_tx_ch10_in;
        ser_drv[`GPD_BIT_TX10]  = 1'b1;
        ser_val[`GPD_BIT_CLK10] = serial_clock_ch10_in;
        ser_drv[`GPD_BIT_CLK10] = serial_clock_ch10_oe_in;
        ser_val[`GPD_BIT_TX11]  = serial_tx_ch11_in;
        ser_drv[`GPD_BIT_TX11]  = 1'b1;
        ser_val[`GPD_BIT_CLK11] = serial_clock_ch11_in;
        ser_drv[`GPD_BIT_CLK11] = serial_clock_ch11_oe_in;
        // receive, interrupt and clear-to-send positions only listen
    end

    // ======================================================================
    // per-pin multiplexer and pad cell
    // ======================================================================
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            gpd_func_t func;                    // owner of this pin
            logic      src_val;                 // level from the owner
            logic      src_drv;                 // owner asks to drive
            logic      drive_req;               // final driver request

            // the selects are meant to be one-hot; a clash is reported,
            // and address wins over serial over flow so the pad stays sane
            always_comb begin
                if (fn_addr_q[gi]) begin
                    func = GPD_FN_ADDR;
                end else if (fn_serial_q[gi]) begin
                    func = GPD_FN_SERIAL;
                end else if (fn_flow_q[gi]) begin
                    func = GPD_FN_FLOW;
                end else begin
                    func = GPD_FN_PORT;         // all zero; see [RQ3]
                end
            end

            // flag the case software was told to avoid; see [RQ4]
            assign conflict[gi] = (fn_addr_q[gi] & fn_serial_q[gi])
                                | (fn_addr_q[gi] & fn_flow_q[gi])
                                | (fn_serial_q[gi] & fn_flow_q[gi]);

            // route the selected function; see [RQ3]
            always_comb begin
                unique case (func)
                    GPD_FN_ADDR: begin
                        src_val = ext_addr_in[gi];   // see [RQ9]
                        src_drv = 1'b1;
                    end
                    GPD_FN_SERIAL: begin
                        src_val = ser_val[gi];       // see [RQ10]
                        src_drv = ser_drv[gi];
                    end
                    GPD_FN_FLOW: begin
                        src_val = 1'b0;              // input only; see [RQ11]
                        src_drv = 1'b0;
                    end
                    GPD_FN_PORT: begin
                        src_val = level_q[gi];       // see [RQ15]
                        src_drv = 1'b1;
                    end
                endcase
            end

            // the output-enable bit gates every driver, so address lines
            // appear only with both bits set; see [RQ5]
            assign drive_req = out_en_q[gi] & src_drv;   // see [RQ8]

            gpd_pin_cell u_cell (
                .clk_in        (clk_in),
                .nrst_in       (rst_n_q),
                .drive_req_in  (drive_req),
                .drive_val_in  (src_val),
                .open_drain_in (open_drain_q[gi]),   // see [RQ12]
                .in_en_in      (in_en_q[gi]),        // see [RQ14]
                .pin_in        (pin_in[gi]),
                .pin_out       (pin_out[gi]),
                .pin_oe_out    (pin_oe_out[gi]),     // see [RQ15]
                .level_out     (pin_level[gi])
            );
        end
    endgenerate

    // ======================================================================
    // inputs to the serial channels and the interrupt controller
    // ======================================================================

    // unselected receive and clock lines idle high, like a quiet line;
    // clear-to-send and interrupt idle low so nothing fires
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            serial_rx_ch10_out     <= 1'b1;
            serial_clock_ch10_out  <= 1'b1;
            clear_to_send_ch10_out <= 1'b0;
        end else begin
            serial_rx_ch10_out     <= fn_serial_q[`GPD_BIT_RX10]
                                    ? pin_level[`GPD_BIT_RX10] : 1'b1;   // see [RQ10]
            serial_clock_ch10_out  <= fn_serial_q[`GPD_BIT_CLK10]
                                    ? pin_level[`GPD_BIT_CLK10] : 1'b1;
            clear_to_send_ch10_out <= fn_flow_q[`GPD_BIT_CLK10]
                                    & pin_level[`GPD_BIT_CLK10];         // see [RQ11]
        end
    end

    // channel 11 sits four bits above channel 10
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            serial_rx_ch11_out     <= 1'b1;
            serial_clock_ch11_out  <= 1'b1;
            clear_to_send_ch11_out <= 1'b0;
        end else begin
            serial_rx_ch11_out     <= fn_serial_q[`GPD_BIT_RX11]
                                    ? pin_level[`GPD_BIT_RX11] : 1'b1;   // see [RQ10]
            serial_clock_ch11_out  <= fn_serial_q[`GPD_BIT_CLK11]
                                    ? pin_level[`GPD_BIT_CLK11] : 1'b1;
            clear_to_send_ch11_out <= fn_flow_q[`GPD_BIT_CLK11]
                                    & pin_level[`GPD_BIT_CLK11];         // see [RQ11]
        end
    end

    // interrupt needs both the select and the input buffer; the level
    // is already zero when the buffer is off
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ext_irq_line_b_out <= 1'b0;
        end else begin
            ext_irq_line_b_out <= fn_serial_q[`GPD_BIT_IRQB]
                                & pin_level[`GPD_BIT_IRQB];              // see [RQ10]
        end
    end

    // ======================================================================
    // read path
    // ======================================================================
    gpd_pins_t level_view;                      // what a data read returns
    gpd_pins_t rd_byte;                         // selected register byte

    // a listening pin reports the pad; a driven or dead pin the latch
    assign level_view = (in_en_q & ~out_en_q & pin_level)
                      | (~(in_en_q & ~out_en_q) & level_q);

    // offset to value; upper bits always zero
    always_comb begin
        unique case (reg_ofs)
            `GPD_OFS_LEVEL:      rd_byte = level_view;     // see [RQ7]
            `GPD_OFS_OUT_EN:     rd_byte = out_en_q;       // see [RQ8]
            `GPD_OFS_FN_ADDR:    rd_byte = fn_addr_q;
            `GPD_OFS_FN_SERIAL:  rd_byte = fn_serial_q;    // bit 3 reads zero
            `GPD_OFS_FN_FLOW:    rd_byte = fn_flow_q;
            `GPD_OFS_OPEN_DRAIN: rd_byte = open_drain_q;
            `GPD_OFS_PULLUP:     rd_byte = pullup_q;
            `GPD_OFS_IN_EN:      rd_byte = in_en_q;
            `GPD_OFS_CONFLICT:   rd_byte = conflict;
            default:             rd_byte = `GPD_RST_BYTE;
        endcase
    end

    // captured in the setup cycle so the access phase sees a flop;
    // an unmapped or foreign address reads zero
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prdata_out <= '0;
        end else if (setup_ph && !pwrite_in) begin
            prdata_out <= ofs_known ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

endmodule // gpd_port

/* File: dv/gpd_port_sva.sv */
// port-level assertions for the port d block
`timescale 1ns/1ps
module gpd_port_sva (
    input wire logic        clk_in, nrst_in, psel_in, penable_in, pwrite_in,
    input wire logic        pready_out, pslverr_out, ext_irq_line_b_out,
    input wire logic [31:0] paddr_in, pwdata_in, prdata_out,
    input wire logic [7:0]  pin_oe_out, pin_pullup_out, pin_ie_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire acc = psel_in & penable_in;
    wire hit = paddr_in[31:8] == 24'h400c03 && paddr_in[7:0] != 8'h14;
    wire wr  = acc & pwrite_in & hit;
    a_ready_high: assert property (acc |-> pready_out) else $error("ready");
    a_err_outside: assert property (acc && !hit |-> pslverr_out) else $error("err");
    a_read_upper: assert property (acc |-> prdata_out[31:8] == 24'h0)
        else $error("upper");
    a_pull_track: assert property (wr && paddr_in[7:0] == 8'h2c |->
        ##2 pin_pullup_out == $past(pwdata_in[7:0], 2)) else $error("pull-up");
    a_ie_track: assert property (wr && paddr_in[7:0] == 8'h38 |->
        ##2 pin_ie_out == $past(pwdata_in[7:0], 2)) else $error("input enable");
    a_oe_clear: assert property (wr && paddr_in[7:0] == 8'h04 &&
        pwdata_in[7:0] == 8'h0 |-> ##2 pin_oe_out == 8'h0) else $error("driver on");
    a_reset_plain: assert property ($rose(nrst_in) |-> pin_oe_out == 8'h0 &&
        pin_pullup_out == 8'h0 && pin_ie_out == 8'h0) else $error("reset state");
    a_irq_gated: assert property ((!pin_ie_out[7]) [*4] |-> !ext_irq_line_b_out)
        else $error("irq gate");
endmodule // gpd_port_sva
bind gpd_port gpd_port_sva i_gpd_port_sva (.*);

/* File: dv/gpd_pad_model.sv */
// board side of the eight pads
`timescale 1ns/1ps
module gpd_pad_model (
    input  wire logic       clk_in, // system clock
    input  wire logic [7:0] d_in,   // design data
    input  wire logic [7:0] oe_in,  // design drives
    input  wire logic [7:0] pu_in,  // pull-up on
    input  wire logic [7:0] bv_in,  // board level
    input  wire logic [7:0] be_in,  // board drives
    output logic      [7:0] lvl_out // wire level
);
    logic [7:0] flt_q = 8'h5a; // toggles so a floating pin never settles
    always_ff @(posedge clk_in) flt_q <= ~flt_q;
    // design, board, then pull-up
    assign lvl_out = oe_in & d_in | ~oe_in & (be_in & bv_in | ~be_in & (pu_in | flt_q));
endmodule // gpd_pad_model

/* File: dv/tb_gpd_port.sv */
// self-checking bench for the port d block
`timescale 1ns/1ps
module tb_gpd_port;
    logic clk_in = '0, nrst_in = '0, psel_in = '0, penable_in = '0, pwrite_in = '0, er;
    logic pready_out, pslverr_out, ext_irq_line_b_out, serial_rx_ch10_out, serial_rx_ch11_out;
    logic serial_tx_ch10_in = '0, serial_clock_ch10_in = '0, serial_clock_ch10_oe_in = '0;
    logic serial_tx_ch11_in = '0, serial_clock_ch11_in = '0, serial_clock_ch11_oe_in = '0;
    logic serial_clock_ch10_out, serial_clock_ch11_out;
    logic clear_to_send_ch10_out, clear_to_send_ch11_out;
    logic [31:0] paddr_in = '0, pwdata_in = '0, prdata_out, rd;
    logic [7:0] pin_in, pin_out, pin_oe_out, pin_pullup_out, pin_ie_out, d, m;
    logic [7:0] ext_addr_in = '0, bv = '0, be = '0;
    logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h28, 8'h2c, 8'h38};
    logic [7:0] msk [8] = '{8'hff, 8'hff, 8'hff, 8'hf7, 8'h44, 8'hff, 8'hff, 8'hff};
    integer err_count = 0, total_checks = 0, seed = 20620, cyc = 0;
    always #2.5 clk_in = ~clk_in;
    gpd_port i_gpd_port (.*);
    gpd_pad_model i_gpd_pad_model (.clk_in(clk_in), .d_in(pin_out), .oe_in(pin_oe_out),
        .pu_in(pin_pullup_out), .bv_in(bv), .be_in(be), .lvl_out(pin_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; random upper bits probe read-as-zero
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= {24'h400c03, a};
        pwdata_in <= $random(seed) & 32'hffff_ff00 | {24'h0, v};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 8'h0);
            chk(rd, 32'h0);
            d = 8'($random(seed));
            apb(1'b1, ofs[i], d);
            apb(1'b0, ofs[i], 8'h0);
            chk(rd, {24'h0, d & msk[i]});
            apb(1'b1, ofs[i], 8'h0);
        end
        apb(1'b0, 8'h14, 8'h0);
        chk({rd[30:0], er}, 32'h1);
        d = 8'($random(seed));
        m = 8'($random(seed));
        apb(1'b1, 8'h00, d);
        apb(1'b1, 8'h04, m);
        repeat (2) @(posedge clk_in);
        chk({pin_oe_out, pin_out & m, pin_in & m}, {m, d & m, d & m});
        ext_addr_in <= 8'($random(seed));
        apb(1'b1, 8'h04, 8'hff);
        apb(1'b1, 8'h08, 8'hff);
        repeat (2) @(posedge clk_in);
        chk(pin_out, ext_addr_in);
        apb(1'b1, 8'h28, 8'hff);
        repeat (2) @(posedge clk_in);
        chk({pin_oe_out ^ ext_addr_in, pin_out}, 16'hff00);
        apb(1'b1, 8'h08, 8'h0);
        apb(1'b1, 8'h04, 8'h0);
        apb(1'b1, 8'h38, 8'hff);
        apb(1'b1, 8'h10, 8'h44);
        bv <= 8'($random(seed));
        be <= 8'hff;
        apb(1'b1, 8'h0c, 8'ha2);
        repeat (4) @(posedge clk_in);
        chk({ext_irq_line_b_out, clear_to_send_ch11_out, serial_rx_ch11_out, clear_to_send_ch10_out,
            serial_rx_ch10_out, serial_clock_ch11_out, serial_clock_ch10_out},
            {bv[7:5], bv[2:1], 2'b11});
        apb(1'b0, 8'h00, 8'h0);
        chk(rd, {24'h0, bv});
        summarize();
    end
endmodule // tb_gpd_port
